/* rsa_top.sv */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "rsa_map.svh"

module rsa_top #(
   parameter logic [31:0] FLASH_HALF_CYC = `RSA_FLASH_HALF_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   // operator and field pins
   input wire logic i_switch_run,
   input wire logic [`RSA_N_INPUTS-1:0] i_field_in,
   // card side
   input wire logic i_card_present,
   input wire logic [1:0] i_card_fs,
   input wire logic i_card_busy,
   input wire logic i_card_error,
   input wire logic i_card_wp,
   output logic o_card_accept,
   output logic o_card_wr_en,
   output logic o_led_sd,
   output logic o_run,
   output logic o_irq,
   // axi4-lite slave
   input wire logic [`RSA_ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [`RSA_ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);

   localparam int NSYNC = `RSA_N_INPUTS + 2;
   localparam int SW_BIT = `RSA_N_INPUTS;
   localparam int WP_BIT = `RSA_N_INPUTS + 1;

   // ------------------------------------------------
   // decode
   // ------------------------------------------------
   function automatic logic is_mapped(input logic [`RSA_ADDR_W-1:0] a);
      is_mapped = (a == `RSA_OFF_CTRL) || (a == `RSA_OFF_STATUS) ||
         (a == `RSA_OFF_IRQ_STAT) || (a == `RSA_OFF_IRQ_MASK) ||
         (a == `RSA_OFF_CARD_CTRL);
   endfunction

   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] filt_q;
   assign pins = {i_card_wp, i_switch_run, i_field_in};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               filt_q[g] <= 1'b0;
            end else begin
               s1_q <= pins[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // level moves once two later stages agree
               if (s2_q == s3_q) begin
                  filt_q[g] <= s3_q;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------
   // registers
   // ------------------------------------------------
   logic in_en_q;
   logic [`RSA_SEL_W-1:0] in_sel_q;
   logic [`RSA_IRQ_W-1:0] irq_stat_q;
   logic [`RSA_IRQ_W-1:0] irq_stat_d;
   logic [`RSA_IRQ_W-1:0] irq_mask_q;
   logic [`RSA_IRQ_W-1:0] irq_set;
   logic cmd_run;
   logic cmd_stop;
   logic clr_err;
   logic stat_rd;

   // ------------------------------------------------
   // write channel
   // ------------------------------------------------
   logic aw_full_q;
   logic w_full_q;
   logic [`RSA_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic wr_lane0;

   assign o_awready = !aw_full_q;
   assign o_wready = !w_full_q;
   assign do_write = aw_full_q && w_full_q && !o_bvalid;
   assign wr_lane0 = do_write && w_strb_q[0];

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (i_awvalid && o_awready) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= i_awaddr;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         w_full_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (i_wvalid && o_wready) begin
         w_full_q <= 1'b1;
         w_data_q <= i_wdata;
         w_strb_q <= i_wstrb;
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= is_mapped(aw_addr_q) ? 2'h0 : 2'h2;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   assign cmd_run = wr_lane0 && (aw_addr_q == `RSA_OFF_CTRL) &&
      w_data_q[`RSA_CTRL_CMD_RUN];
   assign cmd_stop = wr_lane0 && (aw_addr_q == `RSA_OFF_CTRL) &&
      w_data_q[`RSA_CTRL_CMD_STOP];
   assign clr_err = wr_lane0 && (aw_addr_q == `RSA_OFF_CARD_CTRL) &&
      w_data_q[`RSA_CARD_CLR_ERR];

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {in_sel_q, in_en_q} <= `RSA_CTRL_RESET;
      end else if (wr_lane0 && (aw_addr_q == `RSA_OFF_CTRL)) begin
         in_en_q <= w_data_q[`RSA_CTRL_IN_EN];
         // one select field: only one input can be the source
         in_sel_q <= w_data_q[`RSA_CTRL_SEL_HI:`RSA_CTRL_SEL_LO];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_mask_q <= `RSA_MASK_RESET;
      end else if (wr_lane0 && (aw_addr_q == `RSA_OFF_IRQ_MASK)) begin
         irq_mask_q <= w_data_q[`RSA_IRQ_W-1:0];
      end
   end

   // ------------------------------------------------
   // run/stop arbitration
   // ------------------------------------------------
   logic sw_lvl;
   logic sw_prev_q;
   logic in_lvl;
   logic in_prev_q;
   logic in_rise;
   logic sw_rise;
   logic hold_stop;
   rsa_pkg::rsa_state_type state_q;
   rsa_pkg::rsa_state_type state_d;

   assign sw_lvl = filt_q[SW_BIT];
   assign in_lvl = filt_q[in_sel_q];

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sw_prev_q <= 1'b0;
         in_prev_q <= 1'b0;
      end else begin
         sw_prev_q <= sw_lvl;
         in_prev_q <= in_lvl;
      end
   end

   assign sw_rise = sw_lvl && !sw_prev_q;
   assign in_rise = in_en_q && in_lvl && !in_prev_q;
   assign hold_stop = !sw_lvl || (in_en_q && !in_lvl);

   always_comb begin
      state_d = state_q;
      if (hold_stop) begin
         state_d = rsa_pkg::RSA_STOPPED;
      end else if (sw_rise) begin
         state_d = rsa_pkg::RSA_RUNNING;
      end else if (in_rise) begin
         state_d = rsa_pkg::RSA_RUNNING;
      end else begin
         // switch at run, input absent or high: software decides
         unique case (state_q)
            rsa_pkg::RSA_STOPPED: begin
               if (cmd_run) begin
                  state_d = rsa_pkg::RSA_RUNNING;
               end
            end
            rsa_pkg::RSA_RUNNING: begin
               if (cmd_stop) begin
                  state_d = rsa_pkg::RSA_STOPPED;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= rsa_pkg::RSA_STOPPED;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_run = (state_q == rsa_pkg::RSA_RUNNING);

   // ------------------------------------------------
   // card handling
   // ------------------------------------------------
   logic fs_ok;
   logic reject;
   logic reject_q;
   logic err_q;
   logic [31:0] flash_cnt_q;
   logic flash_q;
   logic flash_tick;

   assign fs_ok = (i_card_fs == rsa_pkg::RSA_FS_FAT) ||
      (i_card_fs == rsa_pkg::RSA_FS_FAT32);
   assign reject = i_card_present && !fs_ok;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_card_accept <= 1'b0;
         o_card_wr_en <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         o_card_accept <= i_card_present && fs_ok;
         o_card_wr_en <= i_card_present && fs_ok && !filt_q[WP_BIT];
         reject_q <= reject;
      end
   end

   // error flag: a new error beats a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         err_q <= 1'b0;
      end else if (i_card_error) begin
         err_q <= 1'b1;
      end else if (clr_err) begin
         err_q <= 1'b0;
      end
   end

   assign flash_tick = (flash_cnt_q == FLASH_HALF_CYC - 32'h1);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flash_cnt_q <= '0;
         flash_q <= 1'b0;
      end else if (flash_tick) begin
         flash_cnt_q <= '0;
         flash_q <= !flash_q;
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_led_sd <= 1'b0;
      end else if (err_q) begin
         o_led_sd <= flash_q;
      end else begin
         o_led_sd <= i_card_busy;
      end
   end

   // ------------------------------------------------
   // interrupts
   // ------------------------------------------------
   assign irq_set[`RSA_IRQ_RUN] = (state_d == rsa_pkg::RSA_RUNNING) &&
      (state_q == rsa_pkg::RSA_STOPPED);
   assign irq_set[`RSA_IRQ_STOP] = (state_d == rsa_pkg::RSA_STOPPED) &&
      (state_q == rsa_pkg::RSA_RUNNING);
   assign irq_set[`RSA_IRQ_CARD_ERR] = i_card_error;
   assign irq_set[`RSA_IRQ_REJECT] = reject && !reject_q;

   always_comb begin
      irq_stat_d = irq_stat_q;
      if (stat_rd) begin
         irq_stat_d = '0;
      end
      irq_stat_d = irq_stat_d | irq_set;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_stat_q <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         o_irq <= |(irq_stat_d & irq_mask_q);
      end
   end

   // ------------------------------------------------
   // read channel
   // ------------------------------------------------
   logic [31:0] rd_word;

   assign o_arready = !o_rvalid;
   assign stat_rd = i_arvalid && o_arready &&
      (i_araddr == `RSA_OFF_IRQ_STAT);

   always_comb begin
      rd_word = 32'h0;
      unique case (i_araddr)
         `RSA_OFF_CTRL: rd_word[3:0] = {in_sel_q, in_en_q};
         // relay overload has no input and no flag here
         `RSA_OFF_STATUS: rd_word[6:0] = {o_card_accept, filt_q[WP_BIT],
            err_q, i_card_busy, in_lvl, sw_lvl, o_run};
         `RSA_OFF_IRQ_STAT: rd_word[`RSA_IRQ_W-1:0] = irq_stat_q;
         `RSA_OFF_IRQ_MASK: rd_word[`RSA_IRQ_W-1:0] = irq_mask_q;
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= 2'h0;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= is_mapped(i_araddr) ? 2'h0 : 2'h2;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

endmodule

/* rsa_map.svh */
// Behaviour
// - two-position switch selects run or stop
// - switch, one input, software command control
// - input counts only when configured as source
// - at most one input configured at once
// - stop switch or input low forces stop
// - stop-to-run edge runs if input allows
// - switch at run, input rise commands run
// - switch run, input absent/high: accept commands
// - green led on during card access
// - green led flashes after card error
// - relay overload or short raises nothing
// - accept only fat or fat32 cards
// - write-protected card gets no writes
`ifndef RSA_MAP_SVH
`define RSA_MAP_SVH

// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define RSA_ADDR_W 5
`define RSA_OFF_CTRL 5'h00
`define RSA_OFF_STATUS 5'h04
`define RSA_OFF_IRQ_STAT 5'h08
`define RSA_OFF_IRQ_MASK 5'h0C
`define RSA_OFF_CARD_CTRL 5'h10

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define RSA_CTRL_IN_EN 0
`define RSA_CTRL_SEL_LO 1
`define RSA_CTRL_SEL_HI 3
`define RSA_CTRL_CMD_RUN 4
`define RSA_CTRL_CMD_STOP 5
`define RSA_CARD_CLR_ERR 0
`define RSA_IRQ_RUN 0
`define RSA_IRQ_STOP 1
`define RSA_IRQ_CARD_ERR 2
`define RSA_IRQ_REJECT 3
`define RSA_IRQ_W 4

// ------------------------------------------------
// reset values and widths
// ------------------------------------------------
`define RSA_CTRL_RESET 4'h0
`define RSA_MASK_RESET 4'h0
`define RSA_N_INPUTS 8
`define RSA_SEL_W 3

// ------------------------------------------------
// timing
// ------------------------------------------------
`define RSA_CLK_MHZ 250
`define RSA_FLASH_HALF_MS 250
`define RSA_FLASH_HALF_CYC (`RSA_FLASH_HALF_MS * `RSA_CLK_MHZ * 1000)

`endif

/* rsa_pkg.sv */
package rsa_pkg;

   // ------------------------------------------------
   // types
   // ------------------------------------------------
   typedef enum logic [1:0] {
      RSA_FS_NONE,
      RSA_FS_FAT,
      RSA_FS_FAT32,
      RSA_FS_NTFS
   } rsa_fs_type;

   typedef enum logic {
      RSA_STOPPED,
      RSA_RUNNING
   } rsa_state_type;

endpackage

/* rsa_props.sv */
`timescale 1ns/1ps
module rsa_props #(
   parameter logic [31:0] FLASH_HALF_CYC = 32'h8
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_switch_run,
   input wire logic i_card_present,
   input wire logic [1:0] i_card_fs,
   input wire logic i_card_error,
   input wire logic i_card_wp,
   input wire logic o_card_accept,
   input wire logic o_card_wr_en,
   input wire logic o_led_sd,
   input wire logic o_run,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready
);
   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   sequence wr_both_s;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence fat_card_s;
      i_card_present && (i_card_fs == 2'h1 || i_card_fs == 2'h2);
   endsequence
   wr_answer_a: assert property (wr_both_s |-> ##2 o_bvalid)
      else $error("write answer not on time");
   rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer not on time");
   b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   ar_block_a: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while answer pending");
   stop_hold_a: assert property (!i_switch_run [*6] |-> !o_run)
      else $error("run while switch at stop");
   wp_block_a: assert property (i_card_wp [*6] |-> !o_card_wr_en)
      else $error("writes allowed on locked card");
   wr_accept_a: assert property (o_card_wr_en |-> o_card_accept)
      else $error("writes allowed on unaccepted card");
   ntfs_reject_a: assert property ((i_card_fs == 2'h3) [*3] |-> !o_card_accept)
      else $error("ntfs card accepted");
   fat_accept_a: assert property (fat_card_s [*3] |-> o_card_accept)
      else $error("fat card not accepted");
   led_flash_a: assert property (i_card_error |-> ##[1:20] $changed(o_led_sd))
      else $error("led not flashing after error");
endmodule

bind rsa_top rsa_props #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (.*);

/* rsa_ops_model.sv */
`timescale 1ns/1ps
module rsa_ops_model (
   input wire logic i_clk,
   input wire logic i_sw,
   input wire logic [7:0] i_fld,
   input wire logic i_present,
   input wire logic [1:0] i_fs,
   input wire logic i_busy,
   input wire logic i_err,
   input wire logic i_wp,
   output logic o_switch_run = 1'b0,
   output logic [7:0] o_field_in = 8'h00,
   output logic o_card_present = 1'b0,
   output logic [1:0] o_card_fs = 2'h0,
   output logic o_card_busy = 1'b0,
   output logic o_card_error = 1'b0,
   output logic o_card_wp = 1'b0
);
   logic err_q = 1'b0;
   always @(posedge i_clk) begin
      o_switch_run <= i_sw;
      o_field_in <= i_fld;
      o_card_fs <= i_fs;
      o_card_wp <= i_wp;
      o_card_busy <= i_busy;
      // card stays in while an access runs
      o_card_present <= i_present | (o_card_present & o_card_busy);
      err_q <= i_err;
      o_card_error <= i_err & !err_q;
   end
endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "rsa_map.svh"
module tb;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic sw = 1'b0, present = 1'b0, busy = 1'b0, err = 1'b0, wp = 1'b0;
   logic [7:0] fld = 8'h00;
   logic [1:0] fs = 2'h0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, cfg, v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   wire logic swp, cpr, cbs, cer, cwp, acc, wen, led, run, irq;
   wire logic awr, wrd, bv, arr, rv;
   wire logic [7:0] fin;
   wire logic [1:0] cfs, bresp, rresp;
   wire logic [31:0] rdata;
   int fail_count = 0, n_compared = 0, k, nch;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   always #2 i_clk = ~i_clk;
   rsa_ops_model u_ops (.i_clk(i_clk), .i_sw(sw), .i_fld(fld),
      .i_present(present), .i_fs(fs), .i_busy(busy), .i_err(err),
      .i_wp(wp), .o_switch_run(swp), .o_field_in(fin),
      .o_card_present(cpr), .o_card_fs(cfs), .o_card_busy(cbs),
      .o_card_error(cer), .o_card_wp(cwp));
   rsa_top #(.FLASH_HALF_CYC(32'h8)) u_dut (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_switch_run(swp), .i_field_in(fin),
      .i_card_present(cpr), .i_card_fs(cfs), .i_card_busy(cbs),
      .i_card_error(cer), .i_card_wp(cwp), .o_card_accept(acc),
      .o_card_wr_en(wen), .o_led_sd(led), .o_run(run), .o_irq(irq),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awr),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arr),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rready));
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task cmp_bit(input string n, input logic x, input logic g);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", n, x, g);
      end
   endtask
   task cmp_word(input string n, input logic [33:0] x, input logic [33:0] g);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task conclude;
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task chk_run(input logic x);
      @(negedge i_clk);
      cmp_bit("o_run", x, run);
      @(posedge i_clk);
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] x);
      logic ha, hw, hb;
      logic [1:0] r;
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge i_clk);
         ha = awvalid && awr;
         hw = wvalid && wrd;
         hb = bv;
         r = bresp;
         @(posedge i_clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      cmp_word("bresp", {32'h0, x}, {32'h0, r});
   endtask
   task rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] x);
      logic ha, hr;
      exp_q.push_back({x, d});
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge i_clk);
         ha = arvalid && arr;
         hr = rv;
         @(posedge i_clk);
         if (ha) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   always @(negedge i_clk) begin
      if (rv === 1'b1 && rready === 1'b1) begin
         e = exp_q.pop_front();
         cmp_word("rresp_rdata", e, {rresp, rdata});
      end
   end
   initial begin
      #120000;
      fail_count++;
      conclude();
   end
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial begin
      v = $urandom(32'hd63aa82e);
      step(2);
      i_reset_n <= 1'b1;
      chk_run(1'b0);
      rd(`RSA_OFF_CTRL, 32'h0, 2'b00);
      rd(`RSA_OFF_IRQ_MASK, 32'h0, 2'b00);
      rd(5'h14, 32'h0, 2'b10);
      wr(5'h14, 32'hFFFFFFFF, 2'b10);
      wr(`RSA_OFF_IRQ_MASK, 32'h1, 2'b00);
      wr(`RSA_OFF_CTRL, 32'h10, 2'b00);
      step(3);
      chk_run(1'b0);
      sw <= 1'b1;
      step(10);
      chk_run(1'b1);
      cmp_bit("o_irq", 1'b1, irq);
      rd(`RSA_OFF_IRQ_STAT, 32'h1, 2'b00);
      wr(`RSA_OFF_CTRL, 32'h20, 2'b00);
      step(3);
      chk_run(1'b0);
      cmp_bit("o_irq", 1'b0, irq);
      wr(`RSA_OFF_CTRL, 32'h10, 2'b00);
      step(3);
      chk_run(1'b1);
      rd(`RSA_OFF_IRQ_STAT, 32'h3, 2'b00);
      k = $urandom_range(7, 0);
      cfg = 32'(k) * 2 + 1;
      fld <= ~(8'h01 << k);
      step(6);
      wr(`RSA_OFF_CTRL, cfg, 2'b00);
      step(8);
      chk_run(1'b0);
      fld <= 8'hFF;
      step(8);
      chk_run(1'b1);
      wr(`RSA_OFF_CTRL, cfg | 32'h20, 2'b00);
      step(3);
      chk_run(1'b0);
      wr(`RSA_OFF_CTRL, cfg | 32'h10, 2'b00);
      step(3);
      chk_run(1'b1);
      sw <= 1'b0;
      fld <= 8'h00;
      step(8);
      chk_run(1'b0);
      sw <= 1'b1;
      step(8);
      chk_run(1'b0);
      sw <= 1'b0;
      fld <= 8'hFF;
      step(8);
      sw <= 1'b1;
      step(8);
      chk_run(1'b1);
      rd(`RSA_OFF_IRQ_STAT, 32'h3, 2'b00);
      for (int f = 0; f < 4; f++) begin
         @(posedge i_clk);
         wp <= 1'($urandom);
         present <= 1'b1;
         fs <= 2'(f);
         step(8);
         @(negedge i_clk);
         cmp_bit("o_card_accept", f == 1 || f == 2, acc);
         cmp_bit("o_card_wr_en", (f == 1 || f == 2) && !wp, wen);
      end
      @(posedge i_clk);
      busy <= 1'b1;
      step(3);
      @(negedge i_clk);
      cmp_bit("o_led_sd", 1'b1, led);
      @(posedge i_clk);
      busy <= 1'b0;
      err <= 1'b1;
      @(posedge i_clk);
      err <= 1'b0;
      nch = 0;
      v[0] = led;
      repeat (40) begin
         @(negedge i_clk);
         if (led !== v[0]) nch++;
         v[0] = led;
      end
      cmp_bit("led_toggles", 1'b1, nch >= 4);
      wr(`RSA_OFF_CARD_CTRL, 32'h1, 2'b00);
      step(3);
      @(negedge i_clk);
      cmp_bit("o_led_sd", 1'b0, led);
      rd(`RSA_OFF_IRQ_STAT, 32'hC, 2'b00);
      rd(`RSA_OFF_STATUS, {25'h0, 1'b0, wp, 5'h07}, 2'b00);
      step(2);
      conclude();
   end
endmodule
